// >>> core/cctx_pkg.sv
/*
 Package for the cyclic transmit scheduler and transceiver control port.
 Holds flag-word layout, port-byte layout, sizes and shared types.
 Assumes a single 25 MHz clock domain and a command decoder in front.
*/
package cctx_pkg;
  localparam int unsigned CCTX_CHANNELS = 2;
  localparam int unsigned CCTX_ENTRIES = 16;
  localparam int unsigned CCTX_IDX_W = 4;
  localparam int unsigned CCTX_TIME_W = 32;
  // Flag word bit positions
  localparam int unsigned CCTX_FLAG_START_BIT = 31;
  localparam int unsigned CCTX_FLAG_ORDERED_BIT = 30;
  localparam int unsigned CCTX_SUPPRESS_TX_LOOPBACK_BIT = 16;
  localparam int unsigned CCTX_FLAG_LOCK_LSB = 0;
  // Transceiver port byte
  localparam logic [7:0] CCTX_PORT_TRM = 8'h10;
  localparam logic [7:0] CCTX_PORT_ERR = 8'h20;
  localparam logic [7:0] CCTX_PORT_STB = 8'h40;
  localparam logic [7:0] CCTX_PORT_EN = 8'h80;
  localparam logic [7:0] CCTX_PORT_OUT_MASK = 8'hc0;
  localparam logic [7:0] CCTX_PORT_IN_MASK = 8'h30;
  // Outputs for normal operation after channel init: standby high, enable high
  localparam logic [7:0] CCTX_PORT_INIT = 8'hc0;
  localparam logic [7:0] CCTX_PORT_RST = 8'h00;
  localparam logic [CCTX_TIME_W-1:0] CCTX_TICK_ONE = 32'h0000_0001;

  // Decoded flag word of one channel
  typedef struct packed {
    logic start;
    logic ordered_list_select;
    logic suppress_tx_loopback;
    logic [CCTX_ENTRIES-1:0] lock;
  } cctx_flags_t;

  // Transceiver pins of one channel
  typedef struct packed {
    logic xcvr_standby_out;
    logic xcvr_enable_out;
  } cctx_xcvr_out_t;

  typedef struct packed {
    logic term_resistor_in;
    logic xcvr_fault_in;
  } cctx_xcvr_in_t;

  // Frame request handed to the CAN controller
  typedef struct packed {
    logic [CCTX_IDX_W-1:0] entry;
    logic echo;
  } cctx_txreq_t;
endpackage : cctx_pkg

// >>> core/cctx_top.sv
/*
 Cyclic transmit scheduler and low-speed transceiver port, two channels.
 Assumes a host command decoder drives one-cycle strobes with a channel
 select, a CAN controller that accepts frame requests with valid/ready,
 a millisecond-style tick input, and an outside store that hands back
 saved port outputs on power-on (restore strobe).
*/
`timescale 1ns/1ps
`default_nettype none
module cctx_top #(
  parameter int unsigned NCH = cctx_pkg::CCTX_CHANNELS,
  parameter int unsigned NENT = cctx_pkg::CCTX_ENTRIES,
  parameter bit HS_VARIANT = 1'b0
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Time base
  input wire logic tick,
  // Flag word command
  input wire logic flags_wr,
  input wire logic flags_ch,
  input wire logic [31:0] flags_data,
  // Cyclic set definition (count and per-entry cycle time)
  input wire logic def_wr,
  input wire logic def_ch,
  input wire logic [cctx_pkg::CCTX_IDX_W-1:0] def_idx,
  input wire logic [cctx_pkg::CCTX_TIME_W-1:0] def_time,
  input wire logic [cctx_pkg::CCTX_IDX_W:0] def_count,
  // Channel init and power-on restore
  input wire logic init_ch_stb,
  input wire logic init_ch,
  input wire logic restore_stb,
  input wire logic [7:0] restore_out0,
  input wire logic [7:0] restore_out1,
  // Transceiver port command
  input wire logic port_wr,
  input wire logic port_ch,
  input wire logic [7:0] port_wdata,
  input wire logic port_rd,
  output logic [7:0] port_in_rdata,
  output logic [7:0] port_out_rdata,
  output logic port_rvalid,
  output logic [7:0] saved_out0,
  output logic [7:0] saved_out1,
  // Transceiver pins
  input wire cctx_pkg::cctx_xcvr_in_t [1:0] xcvr_in,
  output cctx_pkg::cctx_xcvr_out_t [1:0] xcvr_out,
  // Frame requests to the CAN controller
  output logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  output cctx_pkg::cctx_txreq_t [1:0] tx_req
);
  import cctx_pkg::*;

  // Port output registers, one per channel
  logic [7:0] port_out_r [2];
  logic [7:0] port_in_r;
  logic [7:0] port_last_r;
  logic port_rvalid_r;

  // Input byte built from pins, unused bits zero
  function automatic logic [7:0] in_byte(input cctx_xcvr_in_t p);
    in_byte = (p.term_resistor_in ? CCTX_PORT_TRM : 8'h00) |
              (p.xcvr_fault_in ? CCTX_PORT_ERR : 8'h00);
  endfunction : in_byte

  wire [7:0] in_sel = in_byte(xcvr_in[port_ch]);
  wire port_wr_ok = port_wr & ~HS_VARIANT;

  // Port outputs per channel: write wins over init, init wins over restore
  for (genvar c = 0; c < 2; c++) begin : g_port
    wire wr_hit = port_wr_ok && (port_ch == c[0]);
    wire init_hit = init_ch_stb && (init_ch == c[0]);
    wire [7:0] rest_v = (c == 0) ? restore_out0 : restore_out1;
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        port_out_r[c] <= CCTX_PORT_RST;
      end else if (clk_en) begin
        if (wr_hit) begin
          port_out_r[c] <= port_wdata & CCTX_PORT_OUT_MASK;
        end else if (init_hit) begin
          port_out_r[c] <= CCTX_PORT_INIT;
        end else if (restore_stb) begin
          port_out_r[c] <= rest_v & CCTX_PORT_OUT_MASK;
        end
      end
    end
    assign xcvr_out[c].xcvr_standby_out = |(port_out_r[c] & CCTX_PORT_STB);
    assign xcvr_out[c].xcvr_enable_out = |(port_out_r[c] & CCTX_PORT_EN);
  end

  assign saved_out0 = port_out_r[0];
  assign saved_out1 = port_out_r[1];

  // Port read answer, one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_in_r <= 8'h00;
      port_last_r <= 8'h00;
      port_rvalid_r <= 1'b0;
    end else if (clk_en) begin
      port_rvalid_r <= port_rd;
      if (port_rd) begin
        port_in_r <= in_sel & CCTX_PORT_IN_MASK;
        port_last_r <= port_out_r[port_ch];
      end
    end
  end
  assign port_in_rdata = port_in_r;
  assign port_out_rdata = port_last_r;
  assign port_rvalid = port_rvalid_r;

  // Scheduler, one instance of state per channel
  for (genvar c = 0; c < 2; c++) begin : g_sch
    cctx_flags_t flags_r;
    logic [CCTX_IDX_W:0] count_r;
    logic [CCTX_TIME_W-1:0] cyc_r [NENT];
    logic [CCTX_TIME_W-1:0] age_r [NENT];
    logic [CCTX_IDX_W-1:0] seq_idx_r;
    logic [CCTX_TIME_W-1:0] seq_age_r;
    logic busy_r;
    cctx_txreq_t req_r;

    wire fl_hit = flags_wr && (flags_ch == c[0]);
    wire df_hit = def_wr && (def_ch == c[0]);
    wire hand = busy_r && tx_ready[c];

    // Lowest due unlocked entry in parallel scheme
    logic [NENT-1:0] due;
    logic par_any;
    logic [CCTX_IDX_W-1:0] par_idx;
    always_comb begin
      par_any = 1'b0;
      par_idx = '0;
      for (int i = NENT - 1; i >= 0; i--) begin
        due[i] = (i < count_r) && (age_r[i] >= cyc_r[i]) && !flags_r.lock[i];
        if (due[i]) begin
          par_any = 1'b1;
          par_idx = i[CCTX_IDX_W-1:0];
        end
      end
    end
    wire seq_due = (count_r != '0) && (seq_age_r >= cyc_r[seq_idx_r]);
    wire seq_lock = flags_r.lock[seq_idx_r];
    wire [CCTX_IDX_W-1:0] seq_next = ({1'b0, seq_idx_r} + 1'b1 >= count_r) ? '0 :
                                     seq_idx_r + 1'b1;
    wire issue_par = flags_r.start && !flags_r.ordered_list_select && !busy_r && par_any;
    wire issue_seq = flags_r.start && flags_r.ordered_list_select && !busy_r && seq_due;

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        flags_r <= '0;
        count_r <= '0;
        seq_idx_r <= '0;
        seq_age_r <= '0;
        busy_r <= 1'b0;
        req_r <= '0;
        for (int i = 0; i < NENT; i++) begin
          cyc_r[i] <= '0;
          age_r[i] <= '0;
        end
      end else if (clk_en) begin
        if (fl_hit) begin
          flags_r.start <= flags_data[CCTX_FLAG_START_BIT];
          flags_r.ordered_list_select <= flags_data[CCTX_FLAG_ORDERED_BIT];
          flags_r.suppress_tx_loopback <= flags_data[CCTX_SUPPRESS_TX_LOOPBACK_BIT];
          flags_r.lock <= flags_data[CCTX_FLAG_LOCK_LSB +: NENT];
          seq_idx_r <= '0;
          seq_age_r <= '0;
        end
        if (df_hit) begin
          cyc_r[def_idx] <= def_time;
          count_r <= (def_count > NENT[CCTX_IDX_W:0]) ? NENT[CCTX_IDX_W:0] : def_count;
        end
        // Per-entry ages advance on tick, cleared on own send
        for (int i = 0; i < NENT; i++) begin
          if (issue_par && par_idx == i[CCTX_IDX_W-1:0]) begin
            age_r[i] <= '0;
          end else if (tick && age_r[i] != '1) begin
            age_r[i] <= age_r[i] + CCTX_TICK_ONE;
          end
        end
        // Sequential: locked entry is passed over without sending
        if (issue_seq) begin
          seq_age_r <= '0;
          seq_idx_r <= seq_next;
        end else if (tick && seq_age_r != '1) begin
          seq_age_r <= seq_age_r + CCTX_TICK_ONE;
        end
        // Request in flight finishes even after stop
        if (hand) begin
          busy_r <= 1'b0;
        end else if (issue_par || (issue_seq && !seq_lock)) begin
          busy_r <= 1'b1;
          req_r.entry <= issue_par ? par_idx : seq_idx_r;
          req_r.echo <= !flags_r.suppress_tx_loopback;
        end
      end
    end
    assign tx_valid[c] = busy_r;
    assign tx_req[c] = req_r;
  end
endmodule : cctx_top
`default_nettype wire

// >>> verification/cctx_far_model.sv
/* Far-side model: transceiver input pins and CAN controller accept.
   Assumes the bench sets pin levels and the accept delay. */
`timescale 1ns/1ps
`default_nettype none
module cctx_far_model (
  // Clock and bench controls
  input wire logic sys_clk,
  input wire logic [3:0] pins,
  input wire logic [3:0] dly,
  // Block side
  output cctx_pkg::cctx_xcvr_in_t [1:0] xcvr_in,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready
);
  import cctx_pkg::*;
  logic [3:0] wait_r [2];
  // Pins follow bench levels; accept after dly held cycles
  assign xcvr_in = pins;
  assign tx_ready[0] = tx_valid[0] && wait_r[0] >= dly;
  assign tx_ready[1] = tx_valid[1] && wait_r[1] >= dly;
  // Count cycles a request has waited
  always_ff @(posedge sys_clk) begin
    wait_r[0] <= (tx_valid[0] && !tx_ready[0]) ? wait_r[0] + 4'h1 : 4'h0;
    wait_r[1] <= (tx_valid[1] && !tx_ready[1]) ? wait_r[1] + 4'h1 : 4'h0;
  end
endmodule : cctx_far_model
`default_nettype wire

// >>> verification/cctx_chk.sv
/* Checker on the channel 0 view of cctx_top.
   Assumes HS_VARIANT 0 and clk_en held high. */
`timescale 1ns/1ps
`default_nettype none
module cctx_chk (
  // Clock and commands
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic flags_wr,
  input wire logic flags_ch,
  input wire logic [31:0] flags_data,
  input wire logic init_ch_stb,
  input wire logic init_ch,
  input wire logic restore_stb,
  input wire logic [7:0] restore_out0,
  input wire logic port_wr,
  input wire logic port_ch,
  input wire logic [7:0] port_wdata,
  input wire logic port_rd,
  // Answers and pins
  input wire logic [7:0] port_in_rdata,
  input wire logic [7:0] port_out_rdata,
  input wire logic port_rvalid,
  input wire logic [7:0] saved_out0,
  input wire cctx_pkg::cctx_xcvr_in_t [1:0] xcvr_in,
  input wire logic [1:0] tx_valid,
  input wire logic [1:0] tx_ready,
  input wire cctx_pkg::cctx_txreq_t [1:0] tx_req
);
  import cctx_pkg::*;
  cctx_flags_t f_r;
  logic [1:0] age_r;
  // Channel 0 flags and cycles since their last write
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      f_r <= '0;
      age_r <= 2'h0;
    end else if (flags_wr && !flags_ch) begin
      f_r <= {flags_data[31:30], flags_data[16:0]};
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_answer;
    ##1 port_rvalid;
  endsequence
  a_read_answer: assert property (port_rd |-> s_answer)
    else $error("read not answered");
  a_in_bits: assert property (port_rd && !port_ch |=> port_in_rdata == {2'h0,
    $past(xcvr_in[0].xcvr_fault_in), $past(xcvr_in[0].term_resistor_in), 4'h0})
    else $error("input bits wrong");
  a_out_read: assert property (port_rd && !port_ch |=> port_out_rdata == $past(saved_out0))
    else $error("last output wrong");
  a_port_write: assert property (port_wr && !port_ch |=>
    saved_out0 == ($past(port_wdata) & CCTX_PORT_OUT_MASK)) else $error("port write lost");
  a_init_out: assert property (init_ch_stb && !init_ch && !port_wr |=>
    saved_out0 == CCTX_PORT_INIT) else $error("init outputs wrong");
  a_restore_out: assert property (restore_stb && !port_wr && !init_ch_stb |=>
    saved_out0 == ($past(restore_out0) & CCTX_PORT_OUT_MASK)) else $error("restore wrong");
  a_req_hold: assert property (tx_valid[0] && !tx_ready[0] |=>
    tx_valid[0] && $stable(tx_req[0])) else $error("request dropped");
  a_stop_quiet: assert property (age_r == 2'h3 && !f_r.start && !tx_valid[0] |=>
    !tx_valid[0]) else $error("request while stopped");
  a_lock_skip: assert property (age_r == 2'h3 && $rose(tx_valid[0]) |->
    !f_r.lock[tx_req[0].entry]) else $error("locked entry sent");
  a_echo_flag: assert property (age_r == 2'h3 && $rose(tx_valid[0]) |->
    tx_req[0].echo == !f_r.suppress_tx_loopback) else $error("echo flag wrong");
endmodule : cctx_chk
bind cctx_top cctx_chk u_chk (.*);
`default_nettype wire

// >>> verification/tb.sv
/* Testbench for cctx_top: port access, init, restore, cyclic requests.
   Assumes the far-side model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cctx_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, tick = 1'b0;
  logic flags_wr = 1'b0, flags_ch = 1'b0, def_wr = 1'b0, def_ch = 1'b0;
  logic init_ch_stb = 1'b0, init_ch = 1'b0, restore_stb = 1'b0;
  logic port_wr = 1'b0, port_ch = 1'b0, port_rd = 1'b0, port_rvalid;
  logic [31:0] flags_data = 32'h0, def_time = 32'h0;
  logic [3:0] def_idx = 4'h0, pins = 4'h0, dly = 4'h0;
  logic [4:0] def_count = 5'h02;
  logic [7:0] restore_out0 = 8'h0, restore_out1 = 8'h0, port_wdata = 8'h0;
  logic [7:0] port_in_rdata, port_out_rdata, saved_out0, saved_out1;
  logic [1:0] tx_valid, tx_ready, tc = 2'h0;
  cctx_xcvr_in_t [1:0] xcvr_in;
  cctx_xcvr_out_t [1:0] xcvr_out;
  cctx_txreq_t [1:0] tx_req;
  int fails = 0, checks_done = 0;
  cctx_top uut (.*);
  cctx_far_model far (.*);
  // Clock and a tick every fourth cycle
  always #20 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    #1;
    tc = tc + 2'h1;
    tick = (tc == 2'h0);
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic finish_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic pwr(input logic ch, input logic [7:0] d);
    port_ch = ch;
    port_wdata = d;
    port_wr = 1'b1;
    step();
    port_wr = 1'b0;
  endtask : pwr
  task automatic prd(input logic ch, input logic [7:0] ein, eout);
    port_ch = ch;
    port_rd = 1'b1;
    step();
    port_rd = 1'b0;
    chk("rvalid", port_rvalid, 1'b1);
    chk("port in", port_in_rdata, ein);
    chk("port out", port_out_rdata, eout);
  endtask : prd
  task automatic fl(input logic [31:0] d);
    flags_data = d;
    flags_wr = 1'b1;
    step();
    flags_wr = 1'b0;
  endtask : fl
  task automatic df(input logic [3:0] i, input logic [31:0] t);
    def_idx = i;
    def_time = t;
    def_wr = 1'b1;
    step();
    def_wr = 1'b0;
  endtask : df
  task automatic wtx(input logic [3:0] e, input logic ec);
    int n;
    n = 0;
    while (tx_valid[0] !== 1'b1 && n < 300) begin
      step();
      n++;
    end
    chk("tx valid", tx_valid[0], 1'b1);
    if (n >= 300) finish_test();
    chk("tx entry", tx_req[0].entry, e);
    chk("tx echo", tx_req[0].echo, ec);
    while (tx_valid[0] === 1'b1 && n < 330) begin
      step();
      n++;
    end
    chk("tx drop", tx_valid[0], 1'b0);
    if (n >= 330) finish_test();
  endtask : wtx
  initial begin
    repeat (2) step();
    rst_n = 1'b1;
    prd(1'b0, 8'h00, 8'h00);
    init_ch_stb = 1'b1;
    step();
    init_ch_stb = 1'b0;
    prd(1'b0, 8'h00, 8'hc0);
    prd(1'b1, 8'h00, 8'h00);
    for (int i = 0; i < 4; i++) begin
      pins = {~2'(i), 2'(i)};
      prd(1'b0, {2'h0, i[0], i[1], 4'h0}, 8'hc0);
      prd(1'b1, {2'h0, ~i[0], ~i[1], 4'h0}, 8'h00);
    end
    pwr(1'b0, 8'h7f);
    prd(1'b0, 8'h30, 8'h40);
    chk("pins 0", xcvr_out[0], 2'b10);
    pwr(1'b1, 8'hbf);
    prd(1'b1, 8'h00, 8'h80);
    chk("pins 1", xcvr_out[1], 2'b01);
    restore_out0 = 8'h5a;
    restore_out1 = 8'ha5;
    restore_stb = 1'b1;
    step();
    restore_stb = 1'b0;
    chk("saved 0", saved_out0, 8'h40);
    chk("saved 1", saved_out1, 8'h80);
    df(4'h0, 32'h3);
    df(4'h1, 32'h3);
    fl(32'hc000_0000);
    wtx(4'h0, 1'b1);
    wtx(4'h1, 1'b1);
    wtx(4'h0, 1'b1);
    dly = 4'h5;
    fl(32'h8001_0001);
    wtx(4'h1, 1'b0);
    wtx(4'h1, 1'b0);
    fl(32'h0000_0000);
    repeat (60) begin
      step();
      chk("stopped", tx_valid, 2'b00);
    end
    finish_test();
  end
endmodule : tb
`default_nettype wire
